// ---- hdl/qagpdr_top.sv ----
// register bank and data path for gain/phase correction and output delay
// assumes samples arrive on every enabled sys_clk and the bus is axi4-lite
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - AB outputs delayed zero to three cycles
// - CD outputs delayed zero to three cycles
// - channel D gain is 11-bit unsigned
// - gain binary point below bit ten
// - dual mode needs bit8 clear, select 11
// - dual mode keeps only B and C
// - AB phase is 12-bit two's complement
// - AB phase resets to zero
// - phase times B added into A
// - AB phase write fires auto-sync
// - sync loads gains and phase together
// - gain writes alone change nothing active
// - CD settings load on CD phase write
module qagpdr_top (
    // clock, reset, enable
    input  wire logic                         sys_clk,
    input  wire logic                         rst_b,
    input  wire logic                         clkEn,
    // axi4-lite write address and data
    input  wire logic                         s_axi_awvalid,
    output var  logic                         s_axi_awready,
    input  wire logic [qagpdr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_wvalid,
    output var  logic                         s_axi_wready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    // axi4-lite write response
    output var  logic                         s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output var  logic [1:0]                   s_axi_bresp,
    // axi4-lite read
    input  wire logic                         s_axi_arvalid,
    output var  logic                         s_axi_arready,
    input  wire logic [qagpdr_pkg::ADDR_W-1:0] s_axi_araddr,
    output var  logic                         s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output var  logic [31:0]                  s_axi_rdata,
    output var  logic [1:0]                   s_axi_rresp,
    // sample path
    input  wire qagpdr_pkg::qagpdr_quad_t     sampIn,
    output var  qagpdr_pkg::qagpdr_quad_t     sampOut
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // byte-lane merge of a 16-bit register, reserved bits forced to zero
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st,
                                            input logic [15:0] keep);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}};
        return ((old & ~m) | (wd[15:0] & m)) & keep;
    endfunction

    // clamp to 16-bit signed so overshoot does not wrap
    function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
        if (v > 20'sh07fff) begin
            return 16'sh7fff;
        end else if (v < -20'sh08000) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

    // x * gain + y * phase, scaled and saturated
    function automatic logic signed [15:0] corr(input logic signed [15:0] x,
                                                input logic [10:0]        g,
                                                input logic signed [15:0] y,
                                                input logic signed [11:0] p);
        logic signed [27:0] gx;
        logic signed [27:0] py;
        logic signed [19:0] s;
        gx = x * $signed({1'b0, g});
        py = y * p;
        s  = 20'(gx >>> qagpdr_pkg::GAIN_FRAC) + 20'(py >>> qagpdr_pkg::PHASE_FRAC);
        return sat16(s);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [qagpdr_pkg::ADDR_W-1:0] awAddr_r;
    logic                          awHeld_r, wHeld_r;
    logic [31:0]                   wData_r;
    logic [3:0]                    wStrb_r;

    logic [15:0] firstCfg_r, gainA_r, gainB_r, gainC_r, chd_r, abPh_r, cdPh_r, sync_r;
    logic [10:0]        actGainA_r, actGainB_r, actGainC_r, actGainD_r;
    logic signed [11:0] actPhAb_r, actPhCd_r;

    logic [5:0]  wrIdx;
    logic [15:0] wrOld, wrKeep, wrVal_nxt, abPhNew, cdPhNew, rdVal_nxt;
    logic        wrHit, doWrite, syncNow, abLoad, cdLoad, rdHit;

    logic signed [15:0] corr_r [4];
    logic signed [15:0] pipe_r [4][qagpdr_pkg::DLY_MAX];
    logic [1:0]         abDly, cdDly;
    logic               dualMode;

    ////////////////////////////////////////////////////////////////////////
    // axi write channels: address and data taken in either order

    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

    // address capture; ready drops once held, returns after the response
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r      <= 1'b0;
            awAddr_r      <= '0;
            s_axi_awready <= 1'b1;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r      <= 1'b1;
                awAddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    // data capture, same scheme
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld_r      <= 1'b0;
            wData_r      <= '0;
            wStrb_r      <= '0;
            s_axi_wready <= 1'b1;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r      <= 1'b1;
                wData_r      <= s_axi_wdata;
                wStrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= qagpdr_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? qagpdr_pkg::RESP_OKAY : qagpdr_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write decode

    assign wrIdx = awAddr_r[qagpdr_pkg::ADDR_W-1:qagpdr_pkg::IDX_LO];

    // current value and writable mask of the addressed register
    always_comb begin
        wrOld  = '0;
        wrKeep = '0;
        wrHit  = 1'b1;
        case (wrIdx)
            qagpdr_pkg::IDX_FIRST_CFG: begin wrOld = firstCfg_r; wrKeep = qagpdr_pkg::MASK_FIRST; end
            qagpdr_pkg::IDX_GAIN_A:    begin wrOld = gainA_r;    wrKeep = qagpdr_pkg::MASK_GAIN;  end
            qagpdr_pkg::IDX_GAIN_B:    begin wrOld = gainB_r;    wrKeep = qagpdr_pkg::MASK_GAIN;  end
            qagpdr_pkg::IDX_GAIN_C:    begin wrOld = gainC_r;    wrKeep = qagpdr_pkg::MASK_GAIN;  end
            qagpdr_pkg::IDX_CHD:       begin wrOld = chd_r;      wrKeep = qagpdr_pkg::MASK_CHD;   end
            qagpdr_pkg::IDX_AB_PHASE:  begin wrOld = abPh_r;     wrKeep = qagpdr_pkg::MASK_ABPH;  end
            qagpdr_pkg::IDX_CD_PHASE:  begin wrOld = cdPh_r;     wrKeep = qagpdr_pkg::MASK_CDPH;  end
            qagpdr_pkg::IDX_SYNC_CFG:  begin wrOld = sync_r;     wrKeep = qagpdr_pkg::MASK_SYNC;  end
            default:                   wrHit = 1'b0;
        endcase
    end

    assign wrVal_nxt = merge16(wrOld, wData_r, wStrb_r, wrKeep);

    // sync-now is a write-only strobe, never stored
    assign syncNow = doWrite && (wrIdx == qagpdr_pkg::IDX_SYNC_CFG) && wStrb_r[0]
                     && wData_r[qagpdr_pkg::SYNC_NOW];

    assign abLoad = syncNow || (doWrite && (wrIdx == qagpdr_pkg::IDX_AB_PHASE)
                     && sync_r[qagpdr_pkg::SYNC_AUTO]);
    assign cdLoad = syncNow || (doWrite && (wrIdx == qagpdr_pkg::IDX_CD_PHASE)
                     && sync_r[qagpdr_pkg::SYNC_AUTO]);

    // the phase just written must reach the active copy in the same load
    assign abPhNew = (doWrite && wrIdx == qagpdr_pkg::IDX_AB_PHASE) ? wrVal_nxt : abPh_r;
    assign cdPhNew = (doWrite && wrIdx == qagpdr_pkg::IDX_CD_PHASE) ? wrVal_nxt : cdPh_r;

    ////////////////////////////////////////////////////////////////////////
    // shadow registers

    // software-visible copies; unmapped writes are dropped
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            firstCfg_r <= qagpdr_pkg::RST_ZERO;
            gainA_r    <= qagpdr_pkg::RST_GAIN;
            gainB_r    <= qagpdr_pkg::RST_GAIN;
            gainC_r    <= qagpdr_pkg::RST_GAIN;
            chd_r      <= qagpdr_pkg::RST_CHD;
            abPh_r     <= qagpdr_pkg::RST_ZERO;
            cdPh_r     <= qagpdr_pkg::RST_ZERO;
            sync_r     <= qagpdr_pkg::RST_ZERO;
        end else if (clkEn && doWrite) begin
            case (wrIdx)
                qagpdr_pkg::IDX_FIRST_CFG: firstCfg_r <= wrVal_nxt;
                qagpdr_pkg::IDX_GAIN_A:    gainA_r    <= wrVal_nxt;
                qagpdr_pkg::IDX_GAIN_B:    gainB_r    <= wrVal_nxt;
                qagpdr_pkg::IDX_GAIN_C:    gainC_r    <= wrVal_nxt;
                qagpdr_pkg::IDX_CHD:       chd_r      <= wrVal_nxt;
                qagpdr_pkg::IDX_AB_PHASE:  abPh_r     <= wrVal_nxt;
                qagpdr_pkg::IDX_CD_PHASE:  cdPh_r     <= wrVal_nxt;
                qagpdr_pkg::IDX_SYNC_CFG:  sync_r     <= wrVal_nxt;
                default:                   ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active correction settings

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            actGainA_r <= qagpdr_pkg::RST_GAIN[10:0];
            actGainB_r <= qagpdr_pkg::RST_GAIN[10:0];
            actPhAb_r  <= '0;
        end else if (clkEn && abLoad) begin
            actGainA_r <= gainA_r[qagpdr_pkg::GAIN_HI:0];
            actGainB_r <= gainB_r[qagpdr_pkg::GAIN_HI:0];
            actPhAb_r  <= abPhNew[qagpdr_pkg::PHASE_HI:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            actGainC_r <= qagpdr_pkg::RST_GAIN[10:0];
            actGainD_r <= qagpdr_pkg::RST_CHD[10:0];
            actPhCd_r  <= '0;
        end else if (clkEn && cdLoad) begin
            actGainC_r <= gainC_r[qagpdr_pkg::GAIN_HI:0];
            actGainD_r <= chd_r[qagpdr_pkg::GAIN_HI:0];
            actPhCd_r  <= cdPhNew[qagpdr_pkg::PHASE_HI:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read

    // read mux; unmapped reads return zero with slverr
    always_comb begin
        rdVal_nxt = '0;
        rdHit     = 1'b1;
        case (s_axi_araddr[qagpdr_pkg::ADDR_W-1:qagpdr_pkg::IDX_LO])
            qagpdr_pkg::IDX_FIRST_CFG: rdVal_nxt = firstCfg_r;
            qagpdr_pkg::IDX_GAIN_A:    rdVal_nxt = gainA_r;
            qagpdr_pkg::IDX_GAIN_B:    rdVal_nxt = gainB_r;
            qagpdr_pkg::IDX_GAIN_C:    rdVal_nxt = gainC_r;
            qagpdr_pkg::IDX_CHD:       rdVal_nxt = chd_r;
            qagpdr_pkg::IDX_AB_PHASE:  rdVal_nxt = abPh_r;
            qagpdr_pkg::IDX_CD_PHASE:  rdVal_nxt = cdPh_r;
            qagpdr_pkg::IDX_SYNC_CFG:  rdVal_nxt = sync_r;
            default:                   rdHit = 1'b0;
        endcase
    end

    // one read in flight; data registered at address acceptance
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= qagpdr_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, rdVal_nxt};
                s_axi_rresp   <= rdHit ? qagpdr_pkg::RESP_OKAY : qagpdr_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path

    assign abDly = chd_r[qagpdr_pkg::AB_DLY_HI:qagpdr_pkg::AB_DLY_LO];
    assign cdDly = chd_r[qagpdr_pkg::CD_DLY_HI:qagpdr_pkg::CD_DLY_LO];

    assign dualMode = !firstCfg_r[qagpdr_pkg::FIRST_DUAL]
                      && (abPh_r[qagpdr_pkg::DUAL_HI:qagpdr_pkg::DUAL_LO]
                          == qagpdr_pkg::DUAL_ON);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            corr_r <= '{default: '0};
        end else if (clkEn) begin
            corr_r[0] <= corr(sampIn.a, actGainA_r, sampIn.b, actPhAb_r);
            corr_r[1] <= corr(sampIn.b, actGainB_r, 16'sh0000, 12'sh000);
            corr_r[2] <= corr(sampIn.c, actGainC_r, sampIn.d, actPhCd_r);
            corr_r[3] <= corr(sampIn.d, actGainD_r, 16'sh0000, 12'sh000);
        end
    end

    // delay taps; fixed latency stays the same for both pairs
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pipe_r <= '{default: '0};
        end else if (clkEn) begin
            for (int i = 0; i < 4; i++) begin
                pipe_r[i][0] <= corr_r[i];
                for (int k = 1; k < qagpdr_pkg::DLY_MAX; k++) begin
                    pipe_r[i][k] <= pipe_r[i][k-1];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sampOut <= '0;
        end else if (clkEn) begin
            sampOut.a <= dualMode ? 16'sh0000 : (abDly == 2'h0 ? corr_r[0] : pipe_r[0][abDly-2'h1]);
            sampOut.b <= (abDly == 2'h0) ? corr_r[1] : pipe_r[1][abDly-2'h1];
            sampOut.c <= (cdDly == 2'h0) ? corr_r[2] : pipe_r[2][cdDly-2'h1];
            sampOut.d <= dualMode ? 16'sh0000 : (cdDly == 2'h0 ? corr_r[3] : pipe_r[3][cdDly-2'h1]);
        end
    end

endmodule

`default_nettype wire

// ---- hdl/qagpdr_pkg.sv ----
// constants, types and register map of the correction/delay register bank
// assumes an axi4-lite master with 32-bit data and byte addresses = 4 * index
package qagpdr_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_FIRST_CFG = 6'h01;
    localparam logic [5:0] IDX_GAIN_A    = 6'h0c;
    localparam logic [5:0] IDX_GAIN_B    = 6'h0d;
    localparam logic [5:0] IDX_GAIN_C    = 6'h0e;
    localparam logic [5:0] IDX_CHD       = 6'h0f;
    localparam logic [5:0] IDX_AB_PHASE  = 6'h10;
    localparam logic [5:0] IDX_CD_PHASE  = 6'h11;
    localparam logic [5:0] IDX_SYNC_CFG  = 6'h1e;
    localparam int ADDR_W = 8;
    localparam int IDX_LO = 2;

    // writable bits of each register; all else reads zero
    localparam logic [15:0] MASK_FIRST = 16'h0100;
    localparam logic [15:0] MASK_GAIN  = 16'h07ff;
    localparam logic [15:0] MASK_CHD   = 16'hf7ff;
    localparam logic [15:0] MASK_ABPH  = 16'h3fff;
    localparam logic [15:0] MASK_CDPH  = 16'h0fff;
    localparam logic [15:0] MASK_SYNC  = 16'h0001;

    // reset values
    localparam logic [15:0] RST_GAIN = 16'h0400;
    localparam logic [15:0] RST_CHD  = 16'h0400;
    localparam logic [15:0] RST_ZERO = 16'h0000;

    // field positions
    localparam int AB_DLY_HI     = 15;
    localparam int AB_DLY_LO     = 14;
    localparam int CD_DLY_HI     = 13;
    localparam int CD_DLY_LO     = 12;
    localparam int DUAL_HI       = 13;
    localparam int DUAL_LO       = 12;
    localparam int GAIN_HI       = 10;
    localparam int PHASE_HI      = 11;
    localparam int FIRST_DUAL    = 8;
    localparam int SYNC_AUTO     = 0;
    localparam int SYNC_NOW      = 1;
    localparam logic [1:0] DUAL_ON = 2'h3;

    // fixed-point scaling: gain has 10 fraction bits, phase 12
    localparam int GAIN_FRAC  = 10;
    localparam int PHASE_FRAC = 12;

    // delay line depth in dac clock cycles
    localparam int DLY_MAX = 3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one sample per channel
    typedef struct packed {
        logic signed [15:0] a;
        logic signed [15:0] b;
        logic signed [15:0] c;
        logic signed [15:0] d;
    } qagpdr_quad_t;
endpackage

// ---- test/qagpdr_sva.sv ----
// concurrent checks on the ports of the correction register bank
// assumes clkEn held high and writes offer address and data together
`timescale 1ns/1ns
`default_nettype none
module qagpdr_sva (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst_b,
    // register bus
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic [7:0]               s_axi_awaddr,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic [31:0]              s_axi_wdata,
    input wire logic [3:0]               s_axi_wstrb,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [7:0]               s_axi_araddr,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    input wire logic [31:0]              s_axi_rdata,
    // samples
    input wire qagpdr_pkg::qagpdr_quad_t sampIn,
    input wire qagpdr_pkg::qagpdr_quad_t sampOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic [5:0] rdIdx_r;
    logic [1:0] dual_r;
    logic       first8_r;
    logic       anyWr_r;
    logic [2:0] cyc_r;
    logic       dualOn;

    ////////////////////////////////////////////////////////////////////////
    // mode tracked at the take edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dual_r   <= 2'h0;
            first8_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_wstrb[1]) begin
            if (s_axi_awaddr[7:2] == qagpdr_pkg::IDX_AB_PHASE)
                dual_r <= s_axi_wdata[13:12];
            if (s_axi_awaddr[7:2] == qagpdr_pkg::IDX_FIRST_CFG)
                first8_r <= s_axi_wdata[8];
        end
    end
    assign dualOn = (dual_r == qagpdr_pkg::DUAL_ON) && !first8_r;

    // read index, write flag, age
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdIdx_r <= 6'h00;
            anyWr_r <= 1'b0;
            cyc_r   <= 3'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready)
                rdIdx_r <= s_axi_araddr[7:2];
            if (s_axi_awvalid)
                anyWr_r <= 1'b1;
            if (cyc_r != 3'h7)
                cyc_r <= cyc_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_chd_resv: assert property (s_axi_rvalid && rdIdx_r == qagpdr_pkg::IDX_CHD
        |-> s_axi_rdata[11] == 1'b0) else $error("reserved delay bit reads one");
    a_abph_resv: assert property (s_axi_rvalid && rdIdx_r == qagpdr_pkg::IDX_AB_PHASE
        |-> s_axi_rdata[15:14] == 2'h0) else $error("reserved phase bits read one");
    a_dual_quiet: assert property (dualOn && $past(dualOn, 6)
        |-> sampOut.a == 16'h0000 && sampOut.d == 16'h0000) else $error("dual mode A or D live");
    a_reset_unity: assert property (!anyWr_r && cyc_r == 3'h7
        |-> sampOut == $past(sampIn, 2)) else $error("reset path not unity");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind qagpdr_top qagpdr_sva u_sva (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .sampIn(sampIn), .sampOut(sampOut)
);
`default_nettype wire

// ---- test/qagpdr_top_tb.sv ----
// self-checking bench for the correction register bank
// assumes the checker is bound in; clkEn and byte strobes held high
`timescale 1ns/1ns
`default_nettype none
module qagpdr_top_tb;
    typedef struct packed {
        logic        doWr;
        logic [5:0]  idx;
        logic [15:0] wd;
        logic [15:0] exp;
    } qagpdr_row_t;
    logic sys_clk, rst_b, ramp, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]               s_axi_awaddr, s_axi_araddr;
    logic [31:0]              s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]               s_axi_bresp, s_axi_rresp, rs;
    qagpdr_pkg::qagpdr_quad_t sampIn, sampOut, old;
    int                       failures, cmp_count, na, nd;
    // reset values first, then masked write-backs
    qagpdr_row_t rows [9] = '{'{1'b0, qagpdr_pkg::IDX_CHD, 16'h0000, 16'h0400},
        '{1'b0, qagpdr_pkg::IDX_AB_PHASE, 16'h0000, 16'h0000},
        '{1'b0, qagpdr_pkg::IDX_GAIN_A, 16'h0000, 16'h0400},
        '{1'b1, qagpdr_pkg::IDX_CHD, 16'hffff, 16'hf7ff},
        '{1'b1, qagpdr_pkg::IDX_CHD, 16'h0400, 16'h0400},
        '{1'b1, qagpdr_pkg::IDX_AB_PHASE, 16'hffff, 16'h3fff},
        '{1'b1, qagpdr_pkg::IDX_AB_PHASE, 16'h0000, 16'h0000},
        '{1'b1, qagpdr_pkg::IDX_FIRST_CFG, 16'hffff, 16'h0100},
        '{1'b1, qagpdr_pkg::IDX_FIRST_CFG, 16'h0000, 16'h0000}};

    qagpdr_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .sampIn(sampIn), .sampOut(sampOut));

    ////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ramp feeds the reset-value check
    always @(posedge sys_clk) if (ramp) sampIn <= {4{sampIn.a + 16'h0101}};
    // hang guard; run needs a few hundred cycles
    initial begin
        #200000;
        failures++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // one transfer; handshakes judged at negedge
    task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] d);
        logic a, wt, b;
        @(posedge sys_clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_araddr <= {idx, 2'h0};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        forever begin
            @(negedge sys_clk);
            a = w ? s_axi_awready : s_axi_arready;
            wt = s_axi_wready;
            b = w ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
            @(posedge sys_clk);
            if (a && w) s_axi_awvalid <= 1'b0;
            if (a && !w) s_axi_arvalid <= 1'b0;
            if (wt && w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run_rows(input int n);
        for (int i = 0; i < n; i++) begin
            if (rows[i].doWr) bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 16'h0000);
            check("readback", {16'h0000, rows[i].exp}, rd);
        end
    endtask
    // settle, then compare all lanes
    task automatic samp_chk(input logic [5:0] idx, input logic [15:0] d, input logic [63:0] e);
        bus(1'b1, idx, d);
        repeat (8) @(negedge sys_clk);
        check("sampOut", e, sampOut);
    endtask
    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        ramp = 1'b1;
        sampIn = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        run_rows(9);
        bus(1'b1, 6'h3f, 16'hffff);
        check("unmapped write resp", qagpdr_pkg::RESP_SLVERR, rs);
        bus(1'b0, 6'h3f, 16'h0000);
        check("unmapped read", {qagpdr_pkg::RESP_SLVERR, 32'h00000000}, {rs, rd});
        ramp <= 1'b0;
        @(posedge sys_clk);
        sampIn <= 64'h03e80190012c00c8;
        samp_chk(qagpdr_pkg::IDX_SYNC_CFG, 16'h0001, 64'h03e80190012c00c8);
        bus(1'b1, qagpdr_pkg::IDX_GAIN_A, 16'h0200);
        samp_chk(qagpdr_pkg::IDX_GAIN_B, 16'h0200, 64'h03e80190012c00c8);
        samp_chk(qagpdr_pkg::IDX_AB_PHASE, 16'h0400, 64'h025800c8012c00c8);
        samp_chk(qagpdr_pkg::IDX_AB_PHASE, 16'h0c00, 64'h019000c8012c00c8);
        samp_chk(qagpdr_pkg::IDX_CHD, 16'h07ff, 64'h019000c8012c00c8);
        samp_chk(qagpdr_pkg::IDX_CD_PHASE, 16'h0000, 64'h019000c8012c018f);
        // delay pairings; negedges from launch until A and D move
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, qagpdr_pkg::IDX_CHD, {k[1:0], 2'(3 - k), 12'h7ff});
            @(posedge sys_clk);
            sampIn.a <= ~sampIn.a;
            sampIn.d <= ~sampIn.d;
            old = sampOut;
            na = 0;
            nd = 0;
            for (int n = 1; n < 9; n++) begin
                @(negedge sys_clk);
                if (na == 0 && sampOut.a !== old.a) na = n;
                if (nd == 0 && sampOut.d !== old.d) nd = n;
            end
            check("ab delay", 3 + k, na);
            check("cd delay", 6 - k, nd);
        end
        samp_chk(qagpdr_pkg::IDX_AB_PHASE, 16'h3000, 64'h000000c8012c0000);
        samp_chk(qagpdr_pkg::IDX_FIRST_CFG, 16'h0100, 64'h01f400c8012c018f);
        // mid-run reset
        @(posedge sys_clk);
        rst_b <= 1'b0;
        ramp <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        run_rows(3);
        repeat (10) @(posedge sys_clk);
        conclude();
    end
endmodule
`default_nettype wire
